/* stw_pkg.sv */
// Purpose: shared constants and types for the second tick watchdog
// Assumes: 100 MHz core clock
// Notes:   register selects are a local two-register port, not a shared bus

package stw_pkg;

	// ********************************************************************
	// register selects and fields
	// ********************************************************************
	localparam logic       STW_SEL_CONTROL = 1'h0;
	localparam logic       STW_SEL_TIMEOUT = 1'h1;
	localparam int         STW_BIT_IRQ_EN  = 7;
	localparam int         STW_BIT_SEL_LO  = 4;
	localparam int         STW_BIT_RSVD    = 3;
	localparam int         STW_BIT_RST_EN  = 2;
	localparam int         STW_BIT_RUN     = 1;
	localparam int         STW_BIT_FIRED   = 0;
	localparam logic [7:0] STW_CTRL_RESET  = 8'h00;
	localparam logic [7:0] STW_TIMEOUT_RST = 8'h00;

	// irq number per select code, code 0 in the low nibble
	localparam logic [31:0] STW_IRQ_MAP = {4'hB, 4'h9, 4'h7, 4'h6, 4'hA, 4'h5, 4'h4, 4'h3};

	// ********************************************************************
	// timing
	// ********************************************************************
	localparam longint STW_SECOND_NS   = 1000000000;
	localparam longint STW_CLOCK_NS    = 10;
	localparam int     STW_TICK_CYCLES = int'(STW_SECOND_NS / STW_CLOCK_NS);

	// control register image
	typedef struct packed {
		logic       irqEnable;
		logic [2:0] irqLineSelect;
		logic       reserved;
		logic       resetEnable;
		logic       watchdogRun;
		logic       firedFlag;
	} stw_ctrl_t;

endpackage

/* stw_second_tick.sv */
// Purpose: free running one second tick
// Assumes: TICK_CYCLES at least 2
// Notes:   never realigned to software writes, so a countdown sees up to one second of slack

`timescale 1ns/1ns

module stw_second_tick
	import stw_pkg::*;
#(
	parameter int TICK_CYCLES = STW_TICK_CYCLES
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// tick out
	output logic      tick
);

	localparam int CW = $clog2(TICK_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] count;

	// wraps after TICK_CYCLES clocks
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			tick <= (count == LAST);
			if (count == LAST) begin
				count <= '0;
			end else begin
				count <= count + 1'b1;
			end
		end
	end

endmodule // stw_second_tick

/* stw_watchdog.sv */
// Purpose: second tick watchdog with irq routing and board reset request
// Assumes: register strobes are one-cycle pulses synchronous to clock
// Notes:   read data appear one cycle after the read strobe

`timescale 1ns/1ns

module stw_watchdog
	import stw_pkg::*;
#(
	parameter int TICK_CYCLES = STW_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// register port
	input  wire logic        regSel,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regWrData,
	output logic      [7:0]  regRdData,
	output logic             regRdValid,
	// system outputs
	output logic      [15:0] serIrq,
	output logic             pbReset
);

	// ********************************************************************
	// state
	// ********************************************************************
	stw_ctrl_t  ctrl;
	logic       irqEnable;
	logic [2:0] irqLineSelect;
	logic       resetEnable;
	logic       watchdogRun;
	logic       firedFlag;
	logic [7:0] timeoutSeconds;
	logic       tick;
	logic       ctrlWrite;
	logic       timeWrite;
	logic [3:0] irqNumber;
	logic [7:0] ctrlImage;

	assign ctrlWrite = regWrite && (regSel == STW_SEL_CONTROL);
	assign timeWrite = regWrite && (regSel == STW_SEL_TIMEOUT);

	// one second time base shared by every count
	stw_second_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.nrst (nrst),
		.tick (tick)
	);

	// ********************************************************************
	// control register
	// ********************************************************************
	// bit 3 and bit 0 are never taken from the write data
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irqEnable     <= STW_CTRL_RESET[STW_BIT_IRQ_EN];
			irqLineSelect <= STW_CTRL_RESET[STW_BIT_SEL_LO +: 3];
			resetEnable   <= STW_CTRL_RESET[STW_BIT_RST_EN];
			watchdogRun   <= STW_CTRL_RESET[STW_BIT_RUN];
		end else if (ctrlWrite) begin
			irqEnable     <= regWrData[STW_BIT_IRQ_EN];
			irqLineSelect <= regWrData[STW_BIT_SEL_LO +: 3];
			resetEnable   <= regWrData[STW_BIT_RST_EN];
			watchdogRun   <= regWrData[STW_BIT_RUN];
		end
	end

	// image built from separate flops so each field keeps a single driver
	assign ctrl = stw_ctrl_t'({irqEnable, irqLineSelect, 1'b0, resetEnable, watchdogRun, firedFlag});

	// ********************************************************************
	// countdown and fired flag
	// ********************************************************************
	// a timeout write always wins over the tick so a kick is never lost
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			timeoutSeconds <= STW_TIMEOUT_RST;
		end else if (timeWrite) begin
			timeoutSeconds <= regWrData;
		end else if (ctrl.watchdogRun && tick && timeoutSeconds != 8'h00) begin
			timeoutSeconds <= timeoutSeconds - 8'h01;
		end
	end

	// status: zero while disabled; a timeout write clears it for one cycle
	// at least, and a zero value written while running sets it again
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			firedFlag <= 1'b0;
		end else if (!ctrl.watchdogRun) begin
			firedFlag <= 1'b0;
		end else if (timeWrite) begin
			firedFlag <= 1'b0;
		end else if (timeoutSeconds == 8'h00) begin
			firedFlag <= 1'b1;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign irqNumber = STW_IRQ_MAP[{ctrl.irqLineSelect, 2'b00} +: 4];

	// one line of sixteen, held while enabled and fired
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			serIrq <= 16'h0000;
		end else begin
			serIrq <= 16'h0000;
			if (ctrl.irqEnable && ctrl.firedFlag) begin
				serIrq[irqNumber] <= 1'b1;
			end
		end
	end

	// level request; the board reset this causes also clears us
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pbReset <= 1'b0;
		end else begin
			pbReset <= ctrl.resetEnable && ctrl.firedFlag;
		end
	end

	assign ctrlImage = ctrl;

	// read data registered one cycle after the strobe
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			regRdData  <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRead;
			if (regRead) begin
				if (regSel == STW_SEL_CONTROL) begin
					regRdData <= ctrlImage;
				end else begin
					regRdData <= timeoutSeconds;
				end
			end
		end
	end

	// ********************************************************************
	// checks
	// ********************************************************************
	chk_irq_route: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl.irqEnable && ctrl.firedFlag) |=> (serIrq == (16'h0001 << $past(irqNumber))))
		else $error("irq line does not match select");

	chk_irq_gate: assert property (@(posedge clock) disable iff (!nrst)
		!(ctrl.irqEnable && ctrl.firedFlag) |=> (serIrq == 16'h0000))
		else $error("irq driven without enable and fired");

	chk_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
		(regRead && regSel == STW_SEL_CONTROL) |=> (regRdValid && !regRdData[STW_BIT_RSVD]))
		else $error("reserved bit read nonzero");

	chk_reset_gate: assert property (@(posedge clock) disable iff (!nrst)
		pbReset |-> $past(ctrl.resetEnable && ctrl.firedFlag))
		else $error("board reset without enable and fired");

	chk_disabled_hold: assert property (@(posedge clock) disable iff (!nrst)
		(!ctrl.watchdogRun && !timeWrite) |=> ($stable(timeoutSeconds) && !ctrl.firedFlag))
		else $error("disabled watchdog counted or fired");

	chk_fire_on_zero: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl.watchdogRun && timeoutSeconds == 8'h00 && !regWrite) |=> ctrl.firedFlag)
		else $error("zero timeout did not fire");

	chk_fire_sticky: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl.firedFlag && ctrl.watchdogRun && !regWrite) |=> ctrl.firedFlag)
		else $error("fired flag dropped on its own");

	chk_write_reload: assert property (@(posedge clock) disable iff (!nrst)
		timeWrite |=> (timeoutSeconds == $past(regWrData) && !ctrl.firedFlag))
		else $error("timeout write did not reload and acknowledge");

	chk_tick_decrement: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl.watchdogRun && tick && !timeWrite && timeoutSeconds != 8'h00)
		|=> (timeoutSeconds == $past(timeoutSeconds) - 8'h01))
		else $error("countdown missed a tick");

	chk_reset_raise: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl.resetEnable && ctrl.firedFlag) |=> pbReset)
		else $error("enabled board reset not requested on fire");

	chk_status_read: assert property (@(posedge clock) disable iff (!nrst)
		(regRead && regSel == STW_SEL_CONTROL) |=> (regRdData[STW_BIT_FIRED] == $past(ctrl.firedFlag)))
		else $error("status bit read does not match fired flag");

	chk_value_read: assert property (@(posedge clock) disable iff (!nrst)
		(regRead && regSel == STW_SEL_TIMEOUT) |=> (regRdData == $past(timeoutSeconds)))
		else $error("timeout read does not return the register");

	chk_count_floor: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl.watchdogRun && tick && !timeWrite && timeoutSeconds == 8'h00) |=> (timeoutSeconds == 8'h00))
		else $error("countdown wrapped below zero");

endmodule // stw_watchdog

/* stw_host_model.sv */
// Purpose: host side model that collects irq and board reset requests
// Assumes: requests are levels from the watchdog
// Notes:   sticky, so a short request is never missed by the bench

`timescale 1ns/1ns

module stw_host_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// requests from the device
	input  wire logic [15:0] serIrq,
	input  wire logic        pbReset,
	// sticky observations
	output logic      [15:0] irqSeen,
	output logic             resetSeen
);
	// capture every request line ever raised
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irqSeen <= 16'h0000;
			resetSeen <= 1'h0;
		end else begin
			irqSeen <= irqSeen | serIrq;
			resetSeen <= resetSeen | pbReset;
		end
	end
endmodule // stw_host_model

/* testbench.sv */
// Purpose: self-checking bench for the second tick watchdog
// Assumes: tick shortened to 16 clocks
// Notes:   free running tick gives up to one tick of slack

`timescale 1ns/1ns

module testbench;
	import stw_pkg::*;
	localparam int TICK = 16;
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic regSel = 1'h0;
	logic regWrite = 1'h0;
	logic regRead = 1'h0;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] regRdData;
	logic regRdValid;
	logic [15:0] serIrq;
	logic pbReset;
	logic [15:0] irqSeen;
	logic resetSeen;
	int failCount = 0;
	int nChecks = 0;
	int cycles = 0;
	logic [3:0] irqNum [8] = '{4'h3, 4'h4, 4'h5, 4'hA, 4'h6, 4'h7, 4'h9, 4'hB};

	stw_watchdog #(.TICK_CYCLES(TICK)) u_dut (.clock(clock), .nrst(nrst), .regSel(regSel),
		.regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .serIrq(serIrq), .pbReset(pbReset));
	stw_host_model u_host (.clock(clock), .nrst(nrst), .serIrq(serIrq), .pbReset(pbReset),
		.irqSeen(irqSeen), .resetSeen(resetSeen));

	// ****************************************************************
	// clock, timeout and shared tasks
	// ****************************************************************
	always #5 clock = ~clock;

	// a hang is cut short well above the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failCount++;
			results();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge clock);
		regSel <= sel;
		regWrite <= 1'h1;
		regWrData <= d;
		@(posedge clock);
		regWrite <= 1'h0;
	endtask

	// read data must arrive exactly one cycle after the strobe
	task automatic rd(input logic sel, input logic [7:0] exp);
		@(posedge clock);
		regSel <= sel;
		regRead <= 1'h1;
		@(posedge clock);
		regRead <= 1'h0;
		#1;
		check({15'h0000, regRdValid}, 16'h0001);
		check({8'h00, regRdData}, {8'h00, exp});
	endtask

	task automatic results();
		$display("checks=%0d failures=%0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic resetAndAccess();
		rd(STW_SEL_CONTROL, 8'h00);
		rd(STW_SEL_TIMEOUT, 8'h00);
		wr(STW_SEL_CONTROL, 8'h09);
		rd(STW_SEL_CONTROL, 8'h00);
		wr(STW_SEL_TIMEOUT, 8'hA5);
		rd(STW_SEL_TIMEOUT, 8'hA5);
	endtask

	// zero timeout with run set fires at once, a timeout write acknowledges
	task automatic zeroFire();
		wr(STW_SEL_TIMEOUT, 8'h00);
		wr(STW_SEL_CONTROL, 8'h86);
		idle(3);
		check(serIrq, 16'h0008);
		check({15'h0000, pbReset}, 16'h0001);
		rd(STW_SEL_CONTROL, 8'h87);
		wr(STW_SEL_TIMEOUT, 8'h05);
		idle(3);
		check(serIrq, 16'h0000);
		check({15'h0000, pbReset}, 16'h0000);
		check({15'h0000, resetSeen}, 16'h0001);
	endtask

	// loaded 3 must fire after more than 2 and at most 3 ticks
	task automatic countdown();
		wr(STW_SEL_TIMEOUT, 8'h03);
		idle(30);
		check(serIrq, 16'h0000);
		idle(22);
		check(serIrq, 16'h0008);
		idle(4);
		check(serIrq, 16'h0008);
	endtask

	task automatic selectAndDisable();
		for (int i = 0; i < 8; i++) begin
			wr(STW_SEL_CONTROL, 8'h82 | (8'(i) << 4));
			idle(3);
			check(serIrq, 16'h0001 << irqNum[i]);
		end
		check(irqSeen, 16'h0EF8);
		wr(STW_SEL_CONTROL, 8'h02);
		idle(3);
		check(serIrq, 16'h0000);
		check({15'h0000, pbReset}, 16'h0000);
		wr(STW_SEL_CONTROL, 8'h00);
		idle(3);
		rd(STW_SEL_CONTROL, 8'h00);
	endtask

	// a kick every ten clocks is shorter than one tick, so the count never
	// reaches zero; then a reset in mid-run must drop every request
	task automatic kickAndReset();
		wr(STW_SEL_TIMEOUT, 8'h02);
		wr(STW_SEL_CONTROL, 8'h86);
		repeat (4) begin
			idle(8);
			check(serIrq, 16'h0000);
			wr(STW_SEL_TIMEOUT, 8'h02);
		end
		idle(16);
		check(serIrq, 16'h0000);
		idle(24);
		check(serIrq, 16'h0008);
		check({15'h0000, pbReset}, 16'h0001);
		@(posedge clock);
		nrst <= 1'h0;
		@(posedge clock);
		#1;
		check(serIrq, 16'h0000);
		check({15'h0000, pbReset}, 16'h0000);
		@(posedge clock);
		nrst <= 1'h1;
		rd(STW_SEL_CONTROL, 8'h00);
		rd(STW_SEL_TIMEOUT, 8'h00);
		wr(STW_SEL_CONTROL, 8'h02);
		rd(STW_SEL_CONTROL, 8'h03);
	endtask

	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'h1;
		resetAndAccess();
		zeroFire();
		countdown();
		selectAndDisable();
		kickAndReset();
		results();
	end
endmodule // testbench
